/* core/cfs_pkg.sv */
//Function
//[RULE1] reset forces interrupt disable, other flags undefined
//[RULE2] software initialises index-X and decimal flags
//[RULE3] push status to stack, read at S+1
//[RULE4] software follows pull status with no-op
//[RULE5] break vectors to highest-priority enabled pending source; code resolves a vector only while interrupt disable is set, else VEC_NONE
//[RULE6] decimal flag makes add/subtract decimal-coded
//[RULE7] software waits one instruction before flag changes
//[RULE8] decimal mode leaves N, V, Z meaningless
//[RULE9] decimal carry is 1, borrow is 0
//[RULE10] software presets carry before decimal arithmetic
//[RULE11] software avoids page-end indirect jump pointer
//[RULE12] multiply/divide ignore index-X and decimal flags
//[RULE13] multiply/divide leave all flags unchanged
//[RULE14] port direction registers read back as zero
//[RULE15] software sets direction registers by plain stores
//[RULE16] execution time is cycles times internal period
//[RULE17] high-speed internal clock is oscillator over two
//[RULE18] software keeps mode bit 3 at one
//[RULE19] operating mode comes from sampled mode pin
//[RULE20] indirect pointer high byte wraps within page
package cfs_pkg;
    // processor status flag image, bit 7 down to bit 0
    typedef struct packed {
        logic n; // negative
        logic v; // overflow
        logic t; // index-X mode
        logic b; // break
        logic d; // decimal
        logic i; // interrupt disable
        logic z; // zero
        logic c; // carry
    } cfs_flags_t;
    // instruction codes accepted on the issue register
    typedef enum logic [3:0] {
        OP_NOP  = 4'b0000,
        OP_PUSH_ST   = 4'b0001,
        OP_PULL_ST   = 4'b0010,
        OP_SET_DEC   = 4'b0011,
        OP_CLR_DEC   = 4'b0100,
        OP_SEC  = 4'b0101,
        OP_CLR_CARRY = 4'b0110,
        OP_SEI  = 4'b0111,
        OP_CLI  = 4'b1000,
        OP_ADC  = 4'b1001,
        OP_SUB  = 4'b1010,
        OP_MULT = 4'b1011,
        OP_DIV  = 4'b1100,
        OP_BREAK = 4'b1101,
        OP_JMPI = 4'b1110,
        OP_SET  = 4'b1111
    } cfs_op_t;
    // register offsets
    localparam logic [7:0] REG_CTRL    = 8'h00;
    localparam logic [7:0] REG_ISSUE   = 8'h01;
    localparam logic [7:0] REG_OPERAND = 8'h02;
    localparam logic [7:0] REG_ACC     = 8'h03;
    localparam logic [7:0] REG_FLAGS   = 8'h04;
    localparam logic [7:0] REG_SP      = 8'h05;
    localparam logic [7:0] REG_STKTOP  = 8'h06;
    localparam logic [7:0] REG_EXT     = 8'h07;
    localparam logic [7:0] REG_IRQREQ  = 8'h08;
    localparam logic [7:0] REG_IRQEN   = 8'h09;
    localparam logic [7:0] REG_VECTOR  = 8'h0A;
    localparam logic [7:0] REG_PORTDIR = 8'h0B;
    localparam logic [7:0] REG_PTRLO   = 8'h0C;
    localparam logic [7:0] REG_PTRHI   = 8'h0D;
    localparam logic [7:0] REG_HFLO    = 8'h0E;
    localparam logic [7:0] REG_HFHI    = 8'h0F;
    localparam logic [7:0] REG_STATE   = 8'h10;
    // reset values and field positions
    localparam logic [7:0] FLAGS_RST   = 8'h04;
    localparam logic [7:0] CTRL_RST    = 8'h08;
    localparam logic [7:0] SP_RST      = 8'hFF;
    localparam int         CTRL_HS     = 0;
    localparam logic [7:0] VEC_NONE    = 8'h0F;
    // oscillator divide counts for high- and middle-speed modes
    localparam logic [3:0] HS_DIV      = 4'h2;
    localparam logic [3:0] MS_DIV      = 4'h8;
    // instruction cycle counts
    function automatic logic [4:0] cfs_op_cycles(input cfs_op_t op);
        unique case (op)
            OP_PUSH_ST: return 5'h03;
            OP_PULL_ST: return 5'h04;
            OP_MULT:    return 5'h0F;
            OP_DIV:     return 5'h10;
            OP_BREAK:   return 5'h07;
            OP_JMPI:    return 5'h05;
            OP_NOP, OP_SET_DEC, OP_CLR_DEC, OP_SEC, OP_CLR_CARRY, OP_SEI, OP_CLI,
            OP_ADC, OP_SUB, OP_SET: return 5'h02;
        endcase
    endfunction : cfs_op_cycles
endpackage : cfs_pkg

/* core/cfs_core.sv */
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
module cfs_core
    import cfs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic [7:0] bus_addr,
    input  wire logic [7:0] bus_wdata,
    input  wire logic       bus_wr,
    input  wire logic       bus_rd,
    output logic      [7:0] bus_rdata,
    input  wire logic       mode_select_pin,
    output cfs_flags_t      status_flags,
    output logic      [7:0] port_dir,
    output logic            processor_mode,
    output logic            busy,
    output logic            phi_en
);
    // decimal add: returns {carry, bcd result}
    function automatic logic [8:0] bcd_add(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        if (lo > 5'h09) lo = lo + 5'h06;
        hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
        if (hi > 5'h09) hi = hi + 5'h06;
        return {hi[4], hi[3:0], lo[3:0]};
    endfunction : bcd_add

    // decimal subtract: carry 1 means no borrow
    function automatic logic [8:0] bcd_sub(input logic [7:0] a, input logic [7:0] b, input logic ci);
        logic [4:0] lo;
        logic [4:0] hi;
        lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~ci};
        if (lo[4]) lo = lo - 5'h06;
        hi = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, lo[4]};
        if (hi[4]) hi = hi - 5'h06;
        return {~hi[4], hi[3:0], lo[3:0]};
    endfunction : bcd_sub

    logic [7:0] ctrl;          // mode control, bit 0 high speed
    logic [7:0] opnd;          // instruction operand
    logic [7:0] acc;           // accumulator
    logic [7:0] ext;           // multiply high byte / remainder
    logic [7:0] sp;            // stack pointer
    logic [7:0] stk [16];      // stack memory
    logic [7:0] irq_req;       // interrupt request bits
    logic [7:0] irq_en;        // interrupt enable bits
    logic [7:0] vector;        // resolved break vector
    logic [7:0] ptr_lo;        // indirect pointer low address
    logic [7:0] ptr_hi;        // indirect pointer page
    logic [7:0] hf_lo;         // high-byte fetch address, low
    logic [7:0] hf_hi;         // high-byte fetch address, page
    logic [2:0] div_cnt;       // oscillator divider
    logic [4:0] cyc_left;      // internal cycles still to run
    cfs_op_t    cur_op;        // instruction in flight
    logic       mode_taken;    // mode pin already captured
    logic       issue;         // accepted issue write
    logic       done;          // last internal cycle of instruction
    logic [7:0] stack_top;     // byte at stack pointer plus one
    logic [7:0] pend;          // enabled pending sources
    logic [7:0] rd_mux;        // read data selection
    cfs_flags_t next_flags;    // flags after instruction
    logic [7:0] next_acc;      // accumulator after instruction
    logic [7:0] next_ext;      // extension after instruction
    logic [8:0] sum;           // adder result with carry
    logic [15:0] prod;         // multiply result

    assign issue     = bus_wr && bus_addr == REG_ISSUE && !busy;
    assign done      = busy && phi_en && cyc_left == 5'h01;
    assign stack_top = stk[sp[3:0] + 4'h1];
    assign pend      = irq_req & irq_en;
    assign prod      = acc * opnd;

    // internal clock enable from the oscillator
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            div_cnt <= 3'h0;
            phi_en  <= 1'b0;
        end else if ({1'b0, div_cnt} >= (ctrl[CTRL_HS] ? HS_DIV : MS_DIV) - 4'h1) begin // [RULE17]
            div_cnt <= 3'h0;
            phi_en  <= 1'b1;
        end else begin
            div_cnt <= div_cnt + 3'h1;
            phi_en  <= 1'b0;
        end
    end

    // instruction sequencing in internal clock cycles
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            busy     <= 1'b0;
            cyc_left <= 5'h00;
            cur_op   <= OP_NOP;
        end else if (issue) begin
            busy     <= 1'b1;
            cur_op   <= cfs_op_t'(bus_wdata[3:0]);
            cyc_left <= cfs_op_cycles(cfs_op_t'(bus_wdata[3:0])); // [RULE16]
        end else if (busy && phi_en) begin
            // count down one internal cycle
            cyc_left <= cyc_left - 5'h01;
            if (cyc_left == 5'h01) busy <= 1'b0; // [RULE16]
        end
    end

    // instruction results
    always_comb begin
        next_flags = status_flags;
        next_acc   = acc;
        next_ext   = ext;
        sum        = 9'h000;
        unique case (cur_op)
            OP_SET_DEC: next_flags.d = 1'b1; // [RULE6]
            OP_CLR_DEC: next_flags.d = 1'b0;
            OP_SEC: next_flags.c = 1'b1;
            OP_CLR_CARRY: next_flags.c = 1'b0;
            OP_SEI: next_flags.i = 1'b1;
            OP_CLI: next_flags.i = 1'b0;
            OP_SET: next_flags.t = 1'b1;
            OP_BREAK: next_flags.i = 1'b1;
            OP_PULL_ST: next_flags = cfs_flags_t'(stack_top); // [RULE3]
            OP_ADC: begin
                // decimal or binary add with carry
                sum = status_flags.d ? bcd_add(acc, opnd, status_flags.c) // [RULE6]
                    : {1'b0, acc} + {1'b0, opnd} + {8'h00, status_flags.c};
                next_acc     = sum[7:0];
                next_flags.c = sum[8]; // [RULE9]
                next_flags.z = sum[7:0] == 8'h00; // [RULE8]
                next_flags.n = sum[7];
                next_flags.v = (acc[7] == opnd[7]) && (sum[7] != acc[7]);
            end
            OP_SUB: begin
                // decimal or binary subtract with borrow
                sum = status_flags.d ? bcd_sub(acc, opnd, status_flags.c) // [RULE6]
                    : {1'b0, acc} + {1'b0, ~opnd} + {8'h00, status_flags.c};
                next_acc     = sum[7:0];
                next_flags.c = sum[8]; // [RULE9]
                next_flags.z = sum[7:0] == 8'h00; // [RULE8]
                next_flags.n = sum[7];
                next_flags.v = (acc[7] != opnd[7]) && (sum[7] != acc[7]);
            end
            OP_MULT: begin
                // binary only, flags kept
                next_acc = prod[7:0]; // [RULE12] [RULE13]
                next_ext = prod[15:8];
            end
            OP_DIV: begin
                // binary only, flags kept; divide by zero gives all ones
                if (opnd == 8'h00) begin
                    next_acc = 8'hFF; // [RULE12] [RULE13]
                    next_ext = acc;
                end else begin
                    next_acc = acc / opnd;
                    next_ext = acc % opnd;
                end
            end
            OP_NOP, OP_PUSH_ST, OP_JMPI: begin
                // no flag or accumulator change
            end
        endcase
    end

    // status flags: reset sets interrupt disable and clears every other flag
    always_ff @(posedge clk or posedge reset) begin
        if (reset) status_flags <= cfs_flags_t'(FLAGS_RST); // [RULE1]
        else if (done) status_flags <= next_flags;
    end

    // accumulator and extension
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            acc <= 8'h00;
            ext <= 8'h00;
        end else if (done) begin
            acc <= next_acc;
            ext <= next_ext;
        end else if (bus_wr && bus_addr == REG_ACC && !busy) begin
            acc <= bus_wdata;
        end
    end

    // stack pointer and stack memory
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sp <= SP_RST;
        end else if (done && cur_op == OP_PUSH_ST) begin
            stk[sp[3:0]] <= status_flags; // [RULE3]
            sp           <= sp - 8'h01;
        end else if (done && cur_op == OP_PULL_ST) begin
            sp <= sp + 8'h01; // [RULE3]
        end else if (bus_wr && bus_addr == REG_SP && !busy) begin
            sp <= bus_wdata;
        end
    end

    // break vector resolution, lowest source index wins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            vector <= VEC_NONE;
        end else if (done && cur_op == OP_BREAK) begin
            vector <= VEC_NONE;
            if (status_flags.i) begin
                for (int k = 7; k >= 0; k--) begin
                    if (pend[k]) vector <= 8'(k); // [RULE5]
                end
            end
        end
    end

    // indirect jump: high byte fetched from same page
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hf_lo <= 8'h00;
            hf_hi <= 8'h00;
        end else if (done && cur_op == OP_JMPI) begin
            hf_lo <= ptr_lo + 8'h01; // [RULE20]
            hf_hi <= ptr_hi;
        end
    end

    // processor mode caught once after reset release
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            processor_mode <= 1'b0;
            mode_taken     <= 1'b0;
        end else if (!mode_taken) begin
            processor_mode <= mode_select_pin; // [RULE19]
            mode_taken     <= 1'b1;
        end
    end

    // software-written configuration registers
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl     <= CTRL_RST;
            opnd     <= 8'h00;
            irq_req  <= 8'h00;
            irq_en   <= 8'h00;
            port_dir <= 8'h00;
            ptr_lo   <= 8'h00;
            ptr_hi   <= 8'h00;
        end else if (bus_wr) begin
            unique case (bus_addr)
                REG_CTRL:    ctrl     <= bus_wdata;
                REG_OPERAND: if (!busy) opnd <= bus_wdata;
                REG_IRQREQ:  irq_req  <= bus_wdata;
                REG_IRQEN:   irq_en   <= bus_wdata;
                REG_PORTDIR: port_dir <= bus_wdata;
                REG_PTRLO:   ptr_lo   <= bus_wdata;
                REG_PTRHI:   ptr_hi   <= bus_wdata;
                default: begin
                    // other offsets hold no storage written in this block
                end
            endcase
        end
    end

    // read selection; direction register reads as zero
    always_comb begin
        unique case (bus_addr)
            REG_CTRL:    rd_mux = ctrl;
            REG_OPERAND: rd_mux = opnd;
            REG_ACC:     rd_mux = acc;
            REG_FLAGS:   rd_mux = status_flags;
            REG_SP:      rd_mux = sp;
            REG_STKTOP:  rd_mux = stack_top; // [RULE3]
            REG_EXT:     rd_mux = ext;
            REG_IRQREQ:  rd_mux = irq_req;
            REG_IRQEN:   rd_mux = irq_en;
            REG_VECTOR:  rd_mux = vector;
            REG_HFLO:    rd_mux = hf_lo;
            REG_HFHI:    rd_mux = hf_hi;
            REG_PTRLO:   rd_mux = ptr_lo;
            REG_PTRHI:   rd_mux = ptr_hi;
            REG_STATE:   rd_mux = {6'h00, processor_mode, busy};
            default:     rd_mux = 8'h00; // [RULE14]
        endcase
    end

    // read data stands one cycle after the strobe only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) bus_rdata <= 8'h00;
        else bus_rdata <= bus_rd ? rd_mux : 8'h00;
    end

    // checking helpers
    logic [7:0] pend_q;        // pending sources one cycle ago
    logic [7:0] busy_clks;     // clocks spent busy
    logic [7:0] low_mask;      // sources below the chosen vector
    logic [7:0] want_clks;     // two clocks per internal cycle
    assign low_mask  = (8'h01 << vector[2:0]) - 8'h01;
    assign want_clks = {2'b00, cfs_op_cycles(cur_op), 1'b0};
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q    <= 8'h00;
            busy_clks <= 8'h00;
        end else begin
            pend_q <= pend;
            if (issue) busy_clks <= 8'h00;
            else if (busy) busy_clks <= busy_clks + 8'h01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    AST_RST_IFLAG: assert property ($fell(reset) |-> status_flags.i) // [RULE1]
        else $error("interrupt disable not set after reset");
    AST_PUSH_STACK: assert property ((done && cur_op == OP_PUSH_ST) |=> stack_top == $past(status_flags)) // [RULE3]
        else $error("pushed status not found at stack pointer plus one");
    AST_PULL_RESTORE: assert property ((done && cur_op == OP_PULL_ST) |=> status_flags == $past(stack_top)) // [RULE3]
        else $error("pulled status not restored");
    AST_BREAK_PRIO: assert property ((done && cur_op == OP_BREAK && status_flags.i && pend != 8'h00)
        |=> pend_q[vector[2:0]] && (pend_q & low_mask) == 8'h00 && !vector[3]) // [RULE5]
        else $error("break did not pick highest priority source");
    AST_DEC_CARRY: assert property ((done && cur_op == OP_ADC && status_flags.d && !status_flags.c
        && acc == 8'h99 && opnd == 8'h01) |=> status_flags.c && acc == 8'h00) // [RULE9]
        else $error("decimal add carry wrong");
    AST_DEC_BORROW: assert property ((done && cur_op == OP_SUB && status_flags.d && status_flags.c
        && acc == 8'h00 && opnd == 8'h01) |=> !status_flags.c && acc == 8'h99) // [RULE6]
        else $error("decimal subtract borrow wrong");
    AST_MULDIV_FLAGS: assert property ((done && (cur_op == OP_MULT || cur_op == OP_DIV)) |=> $stable(status_flags)) // [RULE13]
        else $error("multiply or divide changed flags");
    AST_MULT_BINARY: assert property ((done && cur_op == OP_MULT) |=> {ext, acc} == $past(prod)) // [RULE12]
        else $error("multiply result wrong");
    AST_PORTDIR_RD: assert property ((bus_rd && bus_addr == REG_PORTDIR) |=> bus_rdata == 8'h00) // [RULE14]
        else $error("direction register read back");
    AST_HS_HALF: assert property ((ctrl[CTRL_HS] && phi_en ##1 ctrl[CTRL_HS]) |-> !phi_en ##1 phi_en) // [RULE17]
        else $error("high speed internal clock not half rate");
    AST_EXEC_TIME: assert property (($fell(busy) && ctrl[CTRL_HS])
        |-> busy_clks <= want_clks && busy_clks + 8'h01 >= want_clks) // [RULE16]
        else $error("instruction time wrong");
    AST_JUMP_PAGE: assert property ((done && cur_op == OP_JMPI)
        |=> hf_hi == $past(ptr_hi) && hf_lo == $past(ptr_lo) + 8'h01) // [RULE20]
        else $error("indirect jump left its page");
    AST_MODE_PIN: assert property ($fell(reset) |=> processor_mode == $past(mode_select_pin)) // [RULE19]
        else $error("mode pin not captured");

    COV_PUSH: cover property (done && cur_op == OP_PUSH_ST);
    COV_BREAK: cover property (done && cur_op == OP_BREAK && status_flags.i && pend != 8'h00);
    COV_DEC: cover property (done && cur_op == OP_ADC && status_flags.d);
    COV_JUMP: cover property (done && cur_op == OP_JMPI && ptr_lo == 8'hFF);
endmodule : cfs_core

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
    import cfs_pkg::*;
    logic             clk;              // main oscillator stand-in
    logic             reset;            // async reset, active high
    logic       [7:0] bus_addr;         // register address
    logic       [7:0] bus_wdata;        // write data
    logic             bus_wr;           // write strobe
    logic             bus_rd;           // read strobe
    logic       [7:0] bus_rdata;        // read data
    logic             mode_select_pin;  // processor mode level
    cfs_flags_t       status_flags;     // flag image
    logic       [7:0] port_dir;         // direction register
    logic             processor_mode;   // captured mode
    logic             busy;             // instruction running
    logic             phi_en;           // internal clock enable
    logic       [7:0] rdv;              // last read value
    int               errors;           // mismatch count
    int               total_checks;     // comparison count
    int               cyc;              // busy length in clocks

    cfs_core i_dut (
        .clk             (clk),
        .reset           (reset),
        .bus_addr        (bus_addr),
        .bus_wdata       (bus_wdata),
        .bus_wr          (bus_wr),
        .bus_rd          (bus_rd),
        .bus_rdata       (bus_rdata),
        .mode_select_pin (mode_select_pin),
        .status_flags    (status_flags),
        .port_dir        (port_dir),
        .processor_mode  (processor_mode),
        .busy            (busy),
        .phi_en          (phi_en)
    );

    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // byte comparison
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // count comparison against a window
    task automatic chk_rng(input string name, input int lo, input int hi, input int got);
        total_checks++;
        if (got < lo || got > hi) begin
            errors++;
            $display("[ERR] %s expected %0d..%0d seen %0d", name, lo, hi, got);
        end
    endtask : chk_rng

    // one-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_wr    <= 1'b1;
        bus_addr  <= a;
        bus_wdata <= d;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask : wr

    // one-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        bus_rd   <= 1'b1;
        bus_addr <= a;
        @(posedge clk);
        bus_rd   <= 1'b0;
        #1;
        rdv = bus_rdata;
    endtask : rd

    // issue an opcode and wait, bounded, for busy to drop
    task automatic issue(input cfs_op_t op);
        wr(REG_ISSUE, {4'h0, op});
        cyc = 0;
        #1;
        while (busy === 1'b1 && cyc < 300) begin
            @(posedge clk);
            #1;
            cyc++;
        end
        if (cyc >= 300) chk("busy timeout", 8'h00, 8'h01);
    endtask : issue

    // reset held for ten clocks
    task automatic do_reset();
        reset <= 1'b1;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    // reset image, mode capture, unmapped and read-only places
    task automatic t_reset();
        #1;
        chk("flags", 8'h04, status_flags);
        chk("mode", 8'h01, {7'h00, processor_mode});
        rd(REG_STATE);
        chk("state mode", 8'h01, {7'h00, rdv[1]});
        rd(REG_SP);
        chk("sp", SP_RST, rdv);
        rd(REG_VECTOR);
        chk("vector", VEC_NONE, rdv);
        rd(8'h40);
        chk("unmapped", 8'h00, rdv);
        wr(REG_FLAGS, 8'hFF);
        #1;
        chk("flags ro", 8'h04, status_flags);
        $display("test reset done");
    endtask : t_reset

    // multiply and divide with T and D set keep every flag
    task automatic t_muldiv();
        issue(OP_SET_DEC);
        issue(OP_SET);
        issue(OP_SEC);
        chk("flags pre", 8'h2D, status_flags);
        wr(REG_ACC, 8'h12);
        wr(REG_OPERAND, 8'h10);
        issue(OP_MULT);
        chk("mul flags", 8'h2D, status_flags);
        rd(REG_ACC);
        chk("mul low", 8'h20, rdv);
        rd(REG_EXT);
        chk("mul high", 8'h01, rdv);
        wr(REG_ACC, 8'h64);
        wr(REG_OPERAND, 8'h07);
        issue(OP_DIV);
        chk("div flags", 8'h2D, status_flags);
        rd(REG_ACC);
        chk("div quot", 8'h0E, rdv);
        rd(REG_EXT);
        chk("div rem", 8'h02, rdv);
        $display("test muldiv done");
    endtask : t_muldiv

    // push exposes flags at S+1, pull restores them
    task automatic t_stack();
        issue(OP_PUSH_ST);
        rd(REG_STKTOP);
        chk("stack top", 8'h2D, rdv);
        rd(REG_SP);
        chk("sp push", 8'hFE, rdv);
        issue(OP_CLR_CARRY);
        chk("clear carry", 8'h2C, status_flags);
        issue(OP_PULL_ST);
        issue(OP_NOP);
        chk("pull", 8'h2D, status_flags);
        rd(REG_SP);
        chk("sp pull", SP_RST, rdv);
        $display("test stack done");
    endtask : t_stack

    // decimal add and subtract carry, binary add for contrast
    task automatic t_decimal();
        do_reset();
        issue(OP_CLR_DEC);
        issue(OP_SET_DEC);
        issue(OP_CLR_CARRY);
        wr(REG_ACC, 8'h99);
        wr(REG_OPERAND, 8'h01);
        issue(OP_ADC);
        rd(REG_ACC);
        chk("bcd sum", 8'h00, rdv);
        chk("bcd carry", 8'h01, {7'h00, status_flags.c});
        issue(OP_NOP);
        issue(OP_SEC);
        wr(REG_ACC, 8'h00);
        issue(OP_SUB);
        rd(REG_ACC);
        chk("bcd diff", 8'h99, rdv);
        chk("bcd borrow", 8'h00, {7'h00, status_flags.c});
        issue(OP_NOP);
        issue(OP_CLR_DEC);
        issue(OP_CLR_CARRY);
        wr(REG_ACC, 8'h45);
        wr(REG_OPERAND, 8'h55);
        issue(OP_ADC);
        rd(REG_ACC);
        chk("bin sum", 8'h9A, rdv);
        $display("test decimal done");
    endtask : t_decimal

    // break picks the lowest pending enabled source
    task automatic t_break();
        issue(OP_SEI);
        wr(REG_IRQREQ, 8'h0C);
        wr(REG_IRQEN, 8'h08);
        issue(OP_BREAK);
        rd(REG_VECTOR);
        chk("vec one", 8'h03, rdv);
        wr(REG_IRQEN, 8'h0E);
        issue(OP_BREAK);
        rd(REG_VECTOR);
        chk("vec two", 8'h02, rdv);
        wr(REG_IRQEN, 8'h00);
        issue(OP_BREAK);
        rd(REG_VECTOR);
        chk("vec none", VEC_NONE, rdv);
        $display("test break done");
    endtask : t_break

    // direction register, mid-page and page-wrapped pointer
    task automatic t_port_jmp();
        wr(REG_PORTDIR, 8'hA5);
        #1;
        chk("port dir", 8'hA5, port_dir);
        rd(REG_PORTDIR);
        chk("port dir read", 8'h00, rdv);
        wr(REG_PTRLO, 8'h34);
        wr(REG_PTRHI, 8'h12);
        issue(OP_JMPI);
        rd(REG_HFLO);
        chk("ptr mid", 8'h35, rdv);
        wr(REG_PTRLO, 8'hFF);
        issue(OP_JMPI);
        rd(REG_HFLO);
        chk("ptr lo", 8'h00, rdv);
        rd(REG_HFHI);
        chk("ptr hi", 8'h12, rdv);
        $display("test port jmp done");
    endtask : t_port_jmp

    // execution time in both speeds, phi spacing in high speed
    task automatic t_timing();
        int gap;
        issue(OP_NOP);
        chk_rng("nop mid", 9, 16, cyc);
        wr(REG_CTRL, 8'h09);
        issue(OP_NOP);
        chk_rng("nop high", 3, 4, cyc);
        issue(OP_MULT);
        chk_rng("mul high", 29, 30, cyc);
        gap = 0;
        @(posedge phi_en);
        @(posedge clk);
        #1;
        while (phi_en !== 1'b1 && gap < 20) begin
            @(posedge clk);
            #1;
            gap++;
        end
        chk_rng("phi gap", 1, 1, gap);
        $display("test timing done");
    endtask : t_timing

    // verdict
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up

    // watchdog
    initial begin
        #(20000 * 100);
        errors++;
        wrap_up();
    end

    // main sequence
    initial begin
        reset           = 1'b1;
        bus_addr        = 8'h00;
        bus_wdata       = 8'h00;
        bus_wr          = 1'b0;
        bus_rd          = 1'b0;
        mode_select_pin = 1'b1;
        errors          = 0;
        total_checks    = 0;
        do_reset();
        t_reset();
        t_muldiv();
        t_stack();
        t_decimal();
        t_break();
        t_port_jmp();
        t_timing();
        wrap_up();
    end
endmodule : tb
